// File: async_sram_host.sv
// Host controller: APB register slave driving an asynchronous 16-bit SRAM
//
// Contract
// R1: A write happens only while chip select, at least one lane enable and write enable are all low.
// R2: All three write qualifiers go active to start a write, and raising any one ends it.
// R3: Write data is stable from 9 ns before the write-ending edge until at least 0 ns after it.
// R4: A write cycle lasts at least 20 ns, and chip select, address and lane enables lead the end by 12 ns.
// R5: Write enable stays low at least 12 ns with output enable high, or 17 ns with it low.
// R6: With output enable low through a write, the least write cycle is float delay plus data setup.
// R7: The memory floats its outputs within 9 ns of write enable falling and drives no sooner than 3 ns after it rises.
// R8: The address may change 0 ns after write end, and write enable may fall 0 ns after address valid.
// R9: Under continuous selection new data appears within 20 ns of an address change, held 2.5 ns, cycle 20 ns.
// R10: Read data appears within 8 ns of output enable falling and floats within 8 ns of it rising.
// R11: Read data appears within 20 ns of chip select falling, drives after 3 ns, and floats within 8 ns of release.
// R12: A lane's read data appears within 8 ns of its enable falling and floats within 8 ns of it rising.
// R13: For a read the address is valid no later than the falling edge of chip select.
// R14: During data retention chip select is high and every other input, lanes included, holds a static level.
// R15: The lower lane enable qualifies data bits 0 to 7 and the upper lane enable bits 8 to 15.
// R16: A read needs chip select low and write enable high, and the host never drives data during a read.
// R17: Every nanosecond least time is rounded up to whole clock cycles.
`timescale 1ns/100ps
module async_sram_host #(
    parameter int ADDR_W = 18,
    parameter int DATA_W = 16
) (
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic      [ADDR_W-1:0] sramAddr,
    output logic                   sramCsN,
    output logic                   sramWeN,
    output logic                   sramOeN,
    output logic                   lowerLaneEnableN,
    output logic                   upperLaneEnableN,
    output logic      [DATA_W-1:0] sramDataOut,
    output logic                   sramDataOe,
    input  wire logic [DATA_W-1:0] sramDataIn
);

    localparam int LANE_W = DATA_W / 2;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        sram_host_pkg::seq_state_e state;
        logic [ADDR_W-1:0]         addr;
        logic [DATA_W-1:0]         wdata;
        logic [DATA_W-1:0]         rdata;
        logic [1:0]                lanes;
        logic                      dirWrite;
        logic                      sleep;
        logic                      done;
        logic [31:0]               prdata;
        logic [ADDR_W-1:0]         pinAddr;
        logic                      csN;
        logic                      weN;
        logic                      oeN;
        logic [1:0]                laneN;
        logic [DATA_W-1:0]         dataOut;
        logic                      dataOe;
    } host_s;

    host_s cur;
    host_s next_cur;

    logic                                timerLoad;
    logic [sram_host_pkg::TIMER_W-1:0]   timerValue;
    logic                                timerExpired;
    logic                                setupPhase;
    logic                                accessPhase;
    logic                                mapped;
    logic [1:0]                          reqLanes;
    logic [DATA_W-1:0]                   capData;

    assign setupPhase  = psel && !penable;
    assign accessPhase = psel && penable;
    assign mapped      = (paddr == sram_host_pkg::CTRL_OFS) || (paddr == sram_host_pkg::ADDR_OFS) ||
                         (paddr == sram_host_pkg::WDATA_OFS) || (paddr == sram_host_pkg::RDATA_OFS) ||
                         (paddr == sram_host_pkg::STATUS_OFS);

    // Zero lanes would never qualify a write, so it means both
    assign reqLanes = (cur.lanes == 2'h0) ? 2'h3 : cur.lanes; // R1

    // ------------------------------------------------------------------
    // Per-lane read capture
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_lane
            // Disabled lane floats, so its old byte is kept
            assign capData[g*LANE_W +: LANE_W] = cur.laneN[g] ? cur.rdata[g*LANE_W +: LANE_W]
                                                               : sramDataIn[g*LANE_W +: LANE_W]; // R12 R15
        end
    endgenerate

    sram_wait_timer #(
        .W (sram_host_pkg::TIMER_W)
    ) u_timer (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .load      (timerLoad),
        .loadValue (timerValue),
        .expired   (timerExpired)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_cur   = cur;
        timerLoad  = 1'b0;
        timerValue = '0;

        // Register reads are staged in the setup cycle
        if (setupPhase && !pwrite) begin
            next_cur.prdata = 32'h0000_0000;
            case (paddr)
                sram_host_pkg::CTRL_OFS: begin
                    next_cur.prdata[sram_host_pkg::CTRL_WRITE_BIT] = cur.dirWrite;
                    next_cur.prdata[sram_host_pkg::CTRL_SLEEP_BIT] = cur.sleep;
                    next_cur.prdata[sram_host_pkg::CTRL_LANE_LSB +: 2] = cur.lanes;
                end
                sram_host_pkg::ADDR_OFS:  next_cur.prdata[ADDR_W-1:0] = cur.addr;
                sram_host_pkg::WDATA_OFS: next_cur.prdata[DATA_W-1:0] = cur.wdata;
                sram_host_pkg::RDATA_OFS: next_cur.prdata[DATA_W-1:0] = cur.rdata;
                sram_host_pkg::STATUS_OFS: begin
                    next_cur.prdata[sram_host_pkg::STAT_BUSY_BIT]  = (cur.state != sram_host_pkg::ST_IDLE);
                    next_cur.prdata[sram_host_pkg::STAT_DONE_BIT]  = cur.done;
                    next_cur.prdata[sram_host_pkg::STAT_SLEEP_BIT] = (cur.state == sram_host_pkg::ST_SLEEP);
                end
                default: next_cur.prdata = 32'h0000_0000;
            endcase
        end

        // Done clear first so a completion in the same cycle wins
        if (accessPhase && pwrite) begin
            case (paddr)
                sram_host_pkg::CTRL_OFS: begin
                    next_cur.dirWrite = pwdata[sram_host_pkg::CTRL_WRITE_BIT];
                    next_cur.sleep    = pwdata[sram_host_pkg::CTRL_SLEEP_BIT];
                    next_cur.lanes    = pwdata[sram_host_pkg::CTRL_LANE_LSB +: 2];
                end
                sram_host_pkg::ADDR_OFS:  next_cur.addr  = pwdata[ADDR_W-1:0];
                sram_host_pkg::WDATA_OFS: next_cur.wdata = pwdata[DATA_W-1:0];
                sram_host_pkg::STATUS_OFS: begin
                    if (pwdata[sram_host_pkg::STAT_DONE_BIT]) begin
                        next_cur.done = 1'b0;
                    end
                end
                default: next_cur.done = cur.done;
            endcase
        end

        case (cur.state)
            sram_host_pkg::ST_IDLE: begin
                if (cur.sleep) begin
                    next_cur.state = sram_host_pkg::ST_SLEEP; // R14
                end else if (accessPhase && pwrite && paddr == sram_host_pkg::CTRL_OFS &&
                             pwdata[sram_host_pkg::CTRL_START_BIT]) begin
                    // Address, lanes and select settle first; WE and data drive follow a cycle later,
                    // so the bus is never driven while the chip still sees a read
                    next_cur.pinAddr = cur.addr; // R13
                    next_cur.csN     = 1'b0;
                    next_cur.laneN   = ~reqLanes; // R15
                    if (pwdata[sram_host_pkg::CTRL_WRITE_BIT]) begin
                        next_cur.dataOut = cur.wdata;
                        next_cur.oeN     = 1'b1; // R6
                        next_cur.state   = sram_host_pkg::ST_SETUP;
                    end else begin
                        next_cur.oeN   = 1'b0; // R16
                        next_cur.state = sram_host_pkg::ST_RWAIT;
                        timerLoad      = 1'b1;
                        timerValue     = sram_host_pkg::TIMER_W'(sram_host_pkg::RD_CYC - 1); // R9 R11
                    end
                end
            end
            sram_host_pkg::ST_SETUP: begin
                next_cur.weN   = 1'b0; // R2 R8
                next_cur.dataOe = 1'b1; // R7 R16
                next_cur.state = sram_host_pkg::ST_WPULSE;
                timerLoad      = 1'b1;
                timerValue     = sram_host_pkg::TIMER_W'(sram_host_pkg::WE_CYC - 1); // R5
            end
            sram_host_pkg::ST_WPULSE: begin
                if (timerExpired) begin
                    // All qualifiers release together, data held one more cycle
                    next_cur.weN   = 1'b1; // R2 R3 R4
                    next_cur.csN   = 1'b1;
                    next_cur.laneN = 2'h3;
                    next_cur.state = sram_host_pkg::ST_WEND;
                end
            end
            sram_host_pkg::ST_WEND: begin
                next_cur.dataOe = 1'b0; // R3 R8
                next_cur.done   = 1'b1;
                next_cur.state  = sram_host_pkg::ST_IDLE;
            end
            sram_host_pkg::ST_RWAIT: begin
                if (timerExpired) begin
                    next_cur.rdata = capData; // R9 R10
                    next_cur.csN   = 1'b1;
                    next_cur.oeN   = 1'b1;
                    next_cur.laneN = 2'h3;
                    next_cur.state = sram_host_pkg::ST_REND;
                end
            end
            sram_host_pkg::ST_REND: begin
                // Turnaround cycle covers the output float time
                next_cur.done  = 1'b1; // R10 R11
                next_cur.state = sram_host_pkg::ST_IDLE;
            end
            sram_host_pkg::ST_SLEEP: begin
                if (!cur.sleep) begin
                    next_cur.state = sram_host_pkg::ST_WAKE;
                    timerLoad      = 1'b1;
                    timerValue     = sram_host_pkg::TIMER_W'(sram_host_pkg::WAKE_CYC - 1);
                end
            end
            sram_host_pkg::ST_WAKE: begin
                if (timerExpired) begin
                    next_cur.state = sram_host_pkg::ST_IDLE;
                end
            end
            default: next_cur.state = sram_host_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cur          <= '0;
            cur.state    <= sram_host_pkg::ST_IDLE;
            cur.lanes    <= sram_host_pkg::LANES_RESET;
            cur.csN      <= 1'b1;
            cur.weN      <= 1'b1;
            cur.oeN      <= 1'b1;
            cur.laneN    <= 2'h3;
        end else begin
            cur <= next_cur;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign prdata           = cur.prdata;
    assign pready           = 1'b1;
    assign pslverr          = accessPhase && !mapped;
    assign sramAddr         = cur.pinAddr;
    assign sramCsN          = cur.csN;
    assign sramWeN          = cur.weN;
    assign sramOeN          = cur.oeN;
    assign lowerLaneEnableN = cur.laneN[0];
    assign upperLaneEnableN = cur.laneN[1];
    assign sramDataOut      = cur.dataOut;
    assign sramDataOe       = cur.dataOe;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [7:0] csLowCount;
    logic [7:0] weLowCount;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            csLowCount <= 8'h00;
            weLowCount <= 8'h00;
        end else begin
            csLowCount <= sramCsN ? 8'h00 : csLowCount + 8'h01;
            weLowCount <= sramWeN ? 8'h00 : weLowCount + 8'h01;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_write_qualify: assert property (!sramWeN |-> !sramCsN && !(lowerLaneEnableN && upperLaneEnableN)) // R1
        else $error("write enable low without select or lane");
    a_write_start: assert property ($fell(sramWeN) |-> $past(!sramCsN) && $stable(sramAddr)) // R2
        else $error("write enable fell before select settled");
    a_write_data: assert property ($rose(sramWeN) |-> sramDataOe && $stable(sramDataOut) ##1 $stable(sramDataOut)) // R3
        else $error("write data moved around write end");
    a_write_cycle: assert property ($rose(sramCsN) && $past(!sramWeN) |-> csLowCount >= sram_host_pkg::WR_CS_CYC) // R4
        else $error("write cycle too short");
    a_we_pulse: assert property ($rose(sramWeN) |-> $past(weLowCount) + 8'h01 >= sram_host_pkg::WE_CYC) // R5
        else $error("write pulse too short");
    a_oe_write: assert property (!sramWeN |-> sramOeN) // R6
        else $error("output enable low during write");
    a_addr_hold: assert property ($rose(sramWeN) |-> $stable(sramAddr)) // R8
        else $error("address changed at write end");
    a_read_wait: assert property ($rose(sramCsN) && $past(!sramOeN) |-> csLowCount >= sram_host_pkg::RD_CYC) // R9
        else $error("read sampled too early");
    a_read_release: assert property ($rose(sramOeN) |-> !sramDataOe ##1 !sramDataOe) // R10
        else $error("bus driven before read float");
    a_addr_cs: assert property (!sramCsN && $past(!sramCsN) |-> $stable(sramAddr)) // R13
        else $error("address moved while selected");
    a_retention: assert property (cur.state == sram_host_pkg::ST_SLEEP |->
                                  sramCsN && sramWeN && sramOeN && lowerLaneEnableN && upperLaneEnableN &&
                                  !sramDataOe && $stable(sramAddr)) // R14
        else $error("inputs not static in retention");
    a_lane_keep: assert property ($rose(sramCsN) && $past(!sramOeN) && $past(lowerLaneEnableN) |->
                                  $stable(cur.rdata[LANE_W-1:0])) // R15
        else $error("disabled lower lane captured");
    a_read_nodrive: assert property (!sramOeN || (!sramCsN && sramWeN) |-> !sramDataOe) // R16
        else $error("host drives bus during read");

    c_write: cover property (cur.state == sram_host_pkg::ST_WEND);
    c_read: cover property (cur.state == sram_host_pkg::ST_REND);
    c_sleep: cover property (cur.state == sram_host_pkg::ST_SLEEP ##1 cur.state == sram_host_pkg::ST_WAKE);

endmodule

// File: sram_async_model.sv
// Behavioural model of the asynchronous 16-bit static RAM facing the host
`timescale 1ns/100ps
module sram_async_model #(
    parameter int RD_DLY = 8
) (
    input  wire logic [17:0] sramAddr,
    input  wire logic        sramCsN,
    input  wire logic        sramWeN,
    input  wire logic        sramOeN,
    input  wire logic        lowerLaneEnableN,
    input  wire logic        upperLaneEnableN,
    input  wire logic [15:0] dataIn,
    output logic      [15:0] dataOut
);
    logic [15:0] mem [logic [17:0]];
    logic [17:0] wAddr;
    logic [15:0] wData;
    logic [15:0] word;
    logic [15:0] rd;
    logic [1:0]  wLane;
    logic        writing;
    logic        driveOn;
    initial begin
        writing = 1'b0;
    end
    // ------------------------------------------------------------------
    // Write: captured during the overlap, committed when any one ends it
    // ------------------------------------------------------------------
    always @(sramAddr or sramCsN or sramWeN or lowerLaneEnableN or upperLaneEnableN or dataIn) begin
        if (!sramCsN && !sramWeN && !(lowerLaneEnableN && upperLaneEnableN)) begin
            writing = 1'b1;
            wAddr = sramAddr;
            wData = dataIn;
            wLane = {!upperLaneEnableN, !lowerLaneEnableN};
        end else if (writing) begin
            writing = 1'b0;
            word = mem.exists(wAddr) ? mem[wAddr] : ~wData;
            if (wLane[0]) word[7:0] = wData[7:0];
            if (wLane[1]) word[15:8] = wData[15:8];
            mem[wAddr] = word;
        end
    end
    // ------------------------------------------------------------------
    // Read: slow answer, still inside the access-time limits
    // ------------------------------------------------------------------
    always @* rd = mem.exists(sramAddr) ? mem[sramAddr] : 16'h0000;
    assign driveOn = !sramCsN && sramWeN && !sramOeN;
    // Released lanes show the inverse so a stale byte never looks valid
    assign #(RD_DLY) dataOut = {(driveOn && !upperLaneEnableN) ? rd[15:8] : ~rd[15:8],
                                (driveOn && !lowerLaneEnableN) ? rd[7:0] : ~rd[7:0]};
endmodule

// File: sram_host_pkg.sv
// Package: timing, register map and state codes for the SRAM host controller
package sram_host_pkg;

    // ------------------------------------------------------------------
    // Clock and device timing, in picoseconds
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_PS               = 25000;
    localparam int READ_CYCLE_MIN_PS           = 20000;
    localparam int ADDRESS_TO_DATA_DELAY_PS    = 20000;
    localparam int DATA_HOLD_AFTER_ADDRESS_PS  = 2500;
    localparam int OE_TO_DATA_DELAY_PS         = 8000;
    localparam int LANE_TO_DATA_DELAY_PS       = 8000;
    localparam int CS_TO_DATA_DELAY_PS         = 20000;
    localparam int OUTPUT_FLOAT_DELAY_PS       = 8000;
    localparam int WRITE_CYCLE_MIN_PS          = 20000;
    localparam int CS_TO_WRITE_END_PS          = 12000;
    localparam int WRITE_DATA_SETUP_PS         = 9000;
    localparam int WRITE_DATA_HOLD_PS          = 0;
    localparam int WRITE_PULSE_MIN_OE_HIGH_PS  = 12000;
    localparam int WRITE_PULSE_MIN_OE_LOW_PS   = 17000;
    localparam int WRITE_START_FLOAT_DELAY_PS  = 9000;
    localparam int WRITE_END_DRIVE_DELAY_PS    = 3000;
    localparam int RETENTION_RECOVERY_PS       = READ_CYCLE_MIN_PS;

    // Least times round up, never below one cycle
    function automatic int cyc_up(input int ps);
        int c;
        c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int max2(input int a, input int b);
        return (a > b) ? a : b;
    endfunction

    // ------------------------------------------------------------------
    // Cycle counts
    // ------------------------------------------------------------------
    localparam int WE_CYC      = max2(cyc_up(WRITE_PULSE_MIN_OE_HIGH_PS), cyc_up(WRITE_DATA_SETUP_PS)); // R17
    localparam int WR_CS_CYC   = max2(cyc_up(WRITE_CYCLE_MIN_PS), cyc_up(CS_TO_WRITE_END_PS));         // R17
    localparam int RD_CYC      = max2(max2(cyc_up(ADDRESS_TO_DATA_DELAY_PS), cyc_up(CS_TO_DATA_DELAY_PS)),
                                      max2(max2(cyc_up(OE_TO_DATA_DELAY_PS), cyc_up(LANE_TO_DATA_DELAY_PS)),
                                           cyc_up(READ_CYCLE_MIN_PS)));                              // R17
    localparam int WAKE_CYC    = cyc_up(RETENTION_RECOVERY_PS);
    localparam int TIMER_W     = 4;

    // ------------------------------------------------------------------
    // Register map (byte offsets) and fields
    // ------------------------------------------------------------------
    localparam logic [11:0] CTRL_OFS    = 12'h000;
    localparam logic [11:0] ADDR_OFS    = 12'h004;
    localparam logic [11:0] WDATA_OFS   = 12'h008;
    localparam logic [11:0] RDATA_OFS   = 12'h00C;
    localparam logic [11:0] STATUS_OFS  = 12'h010;

    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_WRITE_BIT = 1;
    localparam int CTRL_SLEEP_BIT = 2;
    localparam int CTRL_LANE_LSB  = 4;
    localparam int STAT_BUSY_BIT  = 0;
    localparam int STAT_DONE_BIT  = 1;
    localparam int STAT_SLEEP_BIT = 2;

    localparam logic [1:0] LANES_RESET = 2'h3;

    // ------------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_SETUP  = 3'b001,
        ST_WPULSE = 3'b010,
        ST_WEND   = 3'b011,
        ST_RWAIT  = 3'b100,
        ST_REND   = 3'b101,
        ST_SLEEP  = 3'b110,
        ST_WAKE   = 3'b111
    } seq_state_e;

endpackage

// File: sram_wait_timer.sv
// Down-counter that times the write pulse, the read wait and the wake-up delay
`timescale 1ns/100ps
module sram_wait_timer #(
    parameter int W = 4
) (
    input  wire logic         mclk,
    input  wire logic         rst_n,
    input  wire logic         load,
    input  wire logic [W-1:0] loadValue,
    output logic              expired
);

    typedef struct packed {
        logic [W-1:0] count;
    } timer_s;

    timer_s cur;
    timer_s next_cur;

    always_comb begin
        next_cur = cur;
        if (load) begin
            next_cur.count = loadValue;
        end else if (cur.count != '0) begin
            next_cur.count = cur.count - 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign expired = (cur.count == '0);

endmodule

// File: tb_async_sram_host.sv
// Self-checking bench for the APB-driven SRAM host controller
`timescale 1ns/100ps
module tb_async_sram_host;
    logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [17:0] sramAddr;
    logic        sramCsN, sramWeN, sramOeN, lowerLaneEnableN, upperLaneEnableN, sramDataOe;
    logic [15:0] sramDataOut, memOut, busLevel, rexp;
    logic [15:0] refm [logic [17:0]];
    logic [17:0] pool [4] = '{18'h00000, 18'h3FFFF, 18'h15555, 18'h2AAAA};
    int          err_count, total_checks;
    assign busLevel = sramDataOe ? sramDataOut : memOut;
    async_sram_host uut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sramAddr(sramAddr), .sramCsN(sramCsN), .sramWeN(sramWeN), .sramOeN(sramOeN),
        .lowerLaneEnableN(lowerLaneEnableN), .upperLaneEnableN(upperLaneEnableN),
        .sramDataOut(sramDataOut), .sramDataOe(sramDataOe), .sramDataIn(busLevel));
    sram_async_model #(.RD_DLY(18)) farEnd (.sramAddr(sramAddr), .sramCsN(sramCsN), .sramWeN(sramWeN),
        .sramOeN(sramOeN), .lowerLaneEnableN(lowerLaneEnableN), .upperLaneEnableN(upperLaneEnableN),
        .dataIn(busLevel), .dataOut(memOut));
    always #12.5 mclk = ~mclk;
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic stop_test();
        if (err_count == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            cmp("pready", 32'h1, 32'h0);
            stop_test();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic poll(input int b, input logic v);
        int n;
        n = 0;
        do begin
            apb(1'b0, sram_host_pkg::STATUS_OFS, 32'h0);
            n++;
        end while (r[b] !== v && n < 20);
        if (r[b] !== v) begin
            cmp("status wait", 32'(v), 32'(r[b]));
            stop_test();
        end
    endtask
    task automatic op(input logic w, input logic [17:0] a, input logic [15:0] d, input logic [1:0] l);
        logic [1:0] m;
        m = (l == 2'b00) ? 2'b11 : l;
        apb(1'b1, sram_host_pkg::ADDR_OFS, {14'h0, a});
        apb(1'b1, sram_host_pkg::WDATA_OFS, {16'h0, d});
        // Start uses the stored lane mask, so store it first
        apb(1'b1, sram_host_pkg::CTRL_OFS, {26'h0, l, 2'b00, w, 1'b0});
        apb(1'b1, sram_host_pkg::CTRL_OFS, {26'h0, l, 2'b00, w, 1'b1});
        poll(1, 1'b1);
        apb(1'b1, sram_host_pkg::STATUS_OFS, 32'h2);
        if (w) begin
            if (m[0]) refm[a][7:0] = d[7:0];
            if (m[1]) refm[a][15:8] = d[15:8];
        end else begin
            if (m[0]) rexp[7:0] = refm[a][7:0];
            if (m[1]) rexp[15:8] = refm[a][15:8];
            apb(1'b0, sram_host_pkg::RDATA_OFS, 32'h0);
            cmp("read data", {16'h0, rexp}, r);
        end
    endtask
    // Host must never drive the bus while output enable is low
    always @(posedge mclk) if (rst_n) cmp("bus drive in read", 32'h0, {31'h0, sramDataOe & ~sramOeN});
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        {mclk, rst_n, psel, penable, pwrite, paddr, pwdata, rexp} = '0;
        err_count = 0;
        total_checks = 0;
        void'($urandom(32'h844bf394));
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        apb(1'b0, sram_host_pkg::CTRL_OFS, 32'h0);
        cmp("ctrl reset", 32'h30, r);
        apb(1'b0, 12'h014, 32'h0);
        cmp("unmapped read", 32'h1, {r[30:0], e});
        apb(1'b1, 12'h014, 32'hFFFFFFFF);
        cmp("unmapped write", 32'h1, {31'h0, e});
        foreach (pool[i]) op(1'b1, pool[i], 16'($urandom), 2'b11);
        repeat (40) op(1'($urandom), pool[$urandom % 4], 16'($urandom), 2'($urandom));
        apb(1'b1, sram_host_pkg::CTRL_OFS, 32'h34);
        poll(2, 1'b1);
        cmp("pins asleep", 32'h1F, {27'h0, sramCsN, sramWeN, sramOeN, lowerLaneEnableN, upperLaneEnableN});
        apb(1'b1, sram_host_pkg::CTRL_OFS, 32'h35);
        apb(1'b0, sram_host_pkg::STATUS_OFS, 32'h0);
        cmp("start while asleep", 32'h5, r);
        apb(1'b1, sram_host_pkg::CTRL_OFS, 32'h30);
        poll(0, 1'b0);
        op(1'b0, pool[1], 16'h0, 2'b00);
        stop_test();
    end
endmodule
